// ===== rtl/pvic_top.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_top #(
	parameter int SAMP_CYC_50 = pvic_pkg::SAMP_CYC_0,
	parameter int SAMP_CYC_100 = pvic_pkg::SAMP_CYC_1,
	parameter int SAMP_CYC_300 = pvic_pkg::SAMP_CYC_2,
	parameter int SAMP_CYC_500 = pvic_pkg::SAMP_CYC_3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [15:0] regRdData,
	input wire logic signed [15:0] samplePct,
	input wire logic signed [15:0] sampleEng,
	input wire logic signed [15:0] junctionComp,
	input wire logic signed [15:0] sensorMv,
	input wire logic signed [15:0] fixedRangeLo,
	input wire logic signed [15:0] fixedRangeHi,
	input wire logic [2:0] digitalIn,
	output logic signed [15:0] processValue,
	output logic signed [15:0] displayValue,
	output logic displayFlash,
	output logic alarmHigh,
	output logic alarmLow,
	output logic sampleDone,
	output logic [1:0] decimalPos
);
	import pvic_pkg::*;

	// all state of the block
	typedef struct packed {
		logic [1:0] inType;
		logic cjcExternal;
		logic underMv;
		logic [1:0] decPos;
		logic [1:0] sampSel;
		logic [7:0] rangeType;
		logic signed [15:0] dropout;
		logic signed [15:0] rangeLo;
		logic signed [15:0] rangeHi;
		logic signed [15:0] ratio;
		logic signed [15:0] bias;
		logic signed [15:0] filtT;
		logic [5:0] diAssign;
		logic [23:0] tickCnt;
		logic signed [31:0] filt;
		logic signed [15:0] pv;
		logic signed [15:0] disp;
		pvic_hold_type holdMode;
		logic flash;
		logic alarmHi;
		logic alarmLo;
		logic done;
		logic [15:0] rdData;
	} pvic_state_type;

	localparam pvic_state_type RESET_STATE = '{
		rangeHi: RST_RANGE_HI,
		ratio: RST_RATIO,
		holdMode: HOLD_OFF,
		default: '0
	};

	pvic_state_type sQ; // registered state
	pvic_state_type sD; // next state

	// integer square root, bit by bit; argument stays below 2^20
	function automatic logic [9:0] pvic_isqrt(input logic [19:0] a);
		logic [9:0] r;
		logic [9:0] t;
		r = '0;
		for (int i = 9; i >= 0; i--) begin
			t = r | 10'(1 << i);
			if ({10'h000, t} * {10'h000, t} <= a) begin
				r = t;
			end
		end
		return r;
	endfunction : pvic_isqrt

	// setting writes are ignored when out of the allowed range
	function automatic logic pvic_in(input logic [15:0] v, input int lo, input int hi);
		return ($signed(v) >= lo) && ($signed(v) <= hi);
	endfunction : pvic_in

	// shared datapath terms, visible to the checks below
	logic tick; // one-cycle sample enable
	logic isDc;
	logic signed [31:0] pct;
	logic signed [31:0] rootOut;
	logic signed [31:0] effLo;
	logic signed [31:0] effHi;
	logic signed [31:0] scaled;
	logic signed [31:0] loLim;
	logic signed [31:0] hiLim;
	logic signed [31:0] comp;
	logic signed [31:0] filtNew;
	logic signed [15:0] pvNew;
	pvic_hold_type modeNow;

	// next-state logic
	always_comb begin
		int limit;
		int tsMs;
		int span;
		int divisor;
		// defaults keep every local defined on every path
		limit = 0;
		tsMs = 1;
		span = 0;
		divisor = 1;
		sD = sQ;
		sD.done = 1'b0;
		sD.rdData = '0;
		// register writes
		if (regWrStb) begin
			unique case (regAddr)
				REG_CONFIG: begin
					sD.inType = regWrData[CFG_TYPE_LSB +: 2];
					sD.cjcExternal = regWrData[CFG_CJC_BIT];
					sD.underMv = regWrData[CFG_UNDER_BIT];
					sD.decPos = regWrData[CFG_DEC_LSB +: 2];
					sD.sampSel = regWrData[CFG_SAMP_LSB +: 2];
					sD.rangeType = regWrData[CFG_RANGE_LSB +: 8];
				end
				REG_DROPOUT: begin
					if (pvic_in(regWrData, 0, PCT_FULL)) sD.dropout = regWrData;
				end
				REG_RANGE_LO: begin
					// temperature ranges are fixed by the sensor range
					if (sQ.inType == IN_DC && pvic_in(regWrData, RANGE_MIN, RANGE_MAX)) begin
						sD.rangeLo = regWrData;
					end
				end
				REG_RANGE_HI: begin
					if (sQ.inType == IN_DC && pvic_in(regWrData, RANGE_MIN, RANGE_MAX)) begin
						sD.rangeHi = regWrData;
					end
				end
				REG_GAIN_RATIO: begin
					if (pvic_in(regWrData, RATIO_MIN, RATIO_MAX)) sD.ratio = regWrData;
				end
				REG_OFFSET_BIAS: begin
					if (pvic_in(regWrData, RANGE_MIN, RANGE_MAX)) sD.bias = regWrData;
				end
				REG_FILTER: begin
					if (pvic_in(regWrData, 0, FILTER_MAX)) sD.filtT = regWrData;
				end
				REG_DI_ASSIGN: sD.diAssign = regWrData[5:0];
				default: ; // read-only or unmapped: ignored
			endcase
		end
		// sample period divider
		unique case (sQ.sampSel)
			2'h0: begin limit = SAMP_CYC_50; tsMs = SAMP_MS_0; end
			2'h1: begin limit = SAMP_CYC_100; tsMs = SAMP_MS_1; end
			2'h2: begin limit = SAMP_CYC_300; tsMs = SAMP_MS_2; end
			default: begin limit = SAMP_CYC_500; tsMs = SAMP_MS_3; end
		endcase
		tick = (int'(sQ.tickCnt) >= limit - 1);
		sD.tickCnt = tick ? '0 : sQ.tickCnt + 24'h000001;
		// root extraction stage
		isDc = (sQ.inType == IN_DC);
		pct = 32'(samplePct);
		if (!isDc || sQ.dropout == 0 || pct <= 0 || pct >= PCT_FULL) begin
			rootOut = pct;
		end else if (pct < 32'(sQ.dropout)) begin
			rootOut = '0;
		end else begin
			rootOut = 32'(pvic_isqrt(20'(pct * PCT_FULL)));
		end
		// range: fixed by the sensor for temperature inputs
		effLo = isDc ? 32'(sQ.rangeLo) : 32'(fixedRangeLo);
		effHi = isDc ? 32'(sQ.rangeHi) : 32'(fixedRangeHi);
		span = effHi - effLo;
		loLim = effLo - span / FS_MARGIN_DIV;
		hiLim = effHi + span / FS_MARGIN_DIV;
		if (isDc) begin
			scaled = effLo + (rootOut * span) / PCT_FULL;
		end else if (sQ.inType == IN_THERMO && !sQ.cjcExternal) begin
			scaled = 32'(sampleEng) + 32'(junctionComp);
		end else begin
			scaled = 32'(sampleEng);
		end
		comp = (scaled * 32'(sQ.ratio)) / RATIO_ONE + 32'(sQ.bias);
		// first-order lag; divisor is T/Ts + 1 with T in tenths of s
		divisor = (int'(sQ.filtT) * MS_PER_TENTH_S) / tsMs + 1;
		filtNew = (sQ.filtT == 0) ? comp : sQ.filt + (comp - sQ.filt) / divisor;
		if (filtNew > hiLim) pvNew = 16'(hiLim);
		else if (filtNew < loLim) pvNew = 16'(loLim);
		else pvNew = 16'(filtNew);
		// hold mode from the inputs it is assigned to; plain hold wins
		modeNow = HOLD_OFF;
		for (int i = 2; i >= 0; i--) begin
			if (digitalIn[i] && sD.diAssign[2*i +: 2] == DI_MIN) modeNow = HOLD_MIN;
		end
		for (int i = 2; i >= 0; i--) begin
			if (digitalIn[i] && sD.diAssign[2*i +: 2] == DI_MAX) modeNow = HOLD_MAX;
		end
		for (int i = 2; i >= 0; i--) begin
			if (digitalIn[i] && sD.diAssign[2*i +: 2] == DI_HOLD) modeNow = HOLD_PLAIN;
		end
		sD.holdMode = modeNow;
		sD.flash = (modeNow != HOLD_OFF);
		// per-sample update
		if (tick) begin
			sD.done = 1'b1;
			sD.filt = filtNew;
			sD.pv = pvNew;
			sD.alarmHi = (scaled > hiLim);
			if (sQ.underMv && sQ.inType == IN_THERMO &&
				(sQ.rangeType == RANGE_TYPE_A || sQ.rangeType == RANGE_TYPE_B)) begin
				sD.alarmLo = (32'(sensorMv) < UNDER_MV_TENTHS);
			end else begin
				sD.alarmLo = (scaled < loLim);
			end
		end
		// displayed value: only the display is held, control sees the live value
		if (modeNow != sQ.holdMode) begin
			sD.disp = sQ.pv; // capture on entry to a hold mode
			if (modeNow == HOLD_OFF && tick) sD.disp = pvNew;
		end else if (tick) begin
			unique case (sQ.holdMode)
				HOLD_OFF: sD.disp = pvNew;
				HOLD_PLAIN: sD.disp = sQ.disp;
				HOLD_MAX: if (pvNew > sQ.disp) sD.disp = pvNew;
				HOLD_MIN: if (pvNew < sQ.disp) sD.disp = pvNew;
			endcase
		end
		// read answers land in the following cycle only
		if (regRdStb) begin
			unique case (regAddr)
				REG_CONFIG: sD.rdData = {sQ.rangeType, sQ.sampSel, sQ.decPos, sQ.underMv,
					sQ.cjcExternal, sQ.inType};
				REG_DROPOUT: sD.rdData = sQ.dropout;
				REG_RANGE_LO: sD.rdData = 16'(effLo);
				REG_RANGE_HI: sD.rdData = 16'(effHi);
				REG_GAIN_RATIO: sD.rdData = sQ.ratio;
				REG_OFFSET_BIAS: sD.rdData = sQ.bias;
				REG_FILTER: sD.rdData = sQ.filtT;
				REG_DI_ASSIGN: sD.rdData = {10'h000, sQ.diAssign};
				REG_PROCESS_VALUE: sD.rdData = sQ.pv;
				REG_DISPLAY: sD.rdData = sQ.disp;
				REG_STATUS: sD.rdData = {11'h000, sQ.holdMode, sQ.flash, sQ.alarmLo, sQ.alarmHi};
				default: sD.rdData = '0; // unmapped reads as zero
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sQ <= RESET_STATE;
		end else begin
			sQ <= sD;
		end
	end

	// outputs straight from the state flops
	assign regRdData = sQ.rdData;
	assign processValue = sQ.pv;
	assign displayValue = sQ.disp;
	assign displayFlash = sQ.flash;
	assign alarmHigh = sQ.alarmHi;
	assign alarmLow = sQ.alarmLo;
	assign sampleDone = sQ.done;
	assign decimalPos = sQ.decPos;

	// checks
	a_root_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!isDc || sQ.dropout == 0 || pct <= 0 || pct >= PCT_FULL) |-> rootOut == pct)
		else $error("root stage did not pass the input through");
	a_root_dropout: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(isDc && sQ.dropout != 0 && pct > 0 && pct < 32'(sQ.dropout)) |-> rootOut == 0)
		else $error("value below dropout not forced to zero");
	a_root_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(isDc && sQ.dropout != 0 && pct >= 32'(sQ.dropout) && pct < PCT_FULL) |->
		(rootOut * rootOut <= pct * PCT_FULL) && ((rootOut + 1) * (rootOut + 1) > pct * PCT_FULL))
		else $error("square root result wrong");
	a_filter_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && sQ.filtT == 0) |=> sQ.filt == $past(comp))
		else $error("zero filter time did not bypass the filter");
	a_pv_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tick |=> (32'(sQ.pv) <= $past(hiLim)) && (32'(sQ.pv) >= $past(loLim)))
		else $error("process value outside its limits");
	a_hold_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sQ.holdMode == HOLD_PLAIN && $past(sQ.holdMode) == HOLD_PLAIN) |-> $stable(sQ.disp))
		else $error("held display changed");
	a_max_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sQ.holdMode == HOLD_MAX && $past(sQ.holdMode) == HOLD_MAX) |-> sQ.disp >= $past(sQ.disp))
		else $error("max hold display decreased");
	a_min_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sQ.holdMode == HOLD_MIN && $past(sQ.holdMode) == HOLD_MIN) |-> sQ.disp <= $past(sQ.disp))
		else $error("min hold display increased");
	a_flash_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(modeNow != HOLD_OFF) |=> displayFlash)
		else $error("display not flashing during hold");
	a_range_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && !isDc && regAddr == REG_RANGE_LO) |=> $stable(sQ.rangeLo))
		else $error("range limit written for temperature input");

	// sample pulse and filter: the lag only closes the gap, never past the input
	a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sampleDone |=> !sampleDone)
		else $error("sample pulse longer than one cycle");
	a_filter_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && sQ.filtT != 0 && comp >= sQ.filt) |=>
		(sQ.filt >= $past(sQ.filt)) && (sQ.filt <= $past(comp)))
		else $error("filter overshot a rising input");
	a_filter_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && sQ.filtT != 0 && comp <= sQ.filt) |=>
		(sQ.filt <= $past(sQ.filt)) && (sQ.filt >= $past(comp)))
		else $error("filter overshot a falling input");

	// scaling chain: junction term, DC span and unit ratio
	a_cjc_inside: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sQ.inType == IN_THERMO && !sQ.cjcExternal) |->
		scaled == 32'(sampleEng) + 32'(junctionComp))
		else $error("internal junction correction missing");
	a_cjc_outside: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sQ.inType == IN_THERMO && sQ.cjcExternal) |-> scaled == 32'(sampleEng))
		else $error("external junction still corrected");
	a_dc_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(isDc && rootOut >= 0 && rootOut <= PCT_FULL && effHi >= effLo) |->
		(scaled >= effLo) && (scaled <= effHi))
		else $error("scaled value left the configured span");
	a_ratio_unit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sQ.ratio == RATIO_ONE) |-> comp == scaled + 32'(sQ.bias))
		else $error("unit ratio altered the value");

	// alarms look at the value ahead of ratio, bias and filter
	a_alarm_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && scaled > hiLim) |=> alarmHigh)
		else $error("high limit alarm missing");
	a_under_mv: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && sQ.underMv && sQ.inType == IN_THERMO && sQ.rangeType == RANGE_TYPE_B &&
		32'(sensorMv) < UNDER_MV_TENTHS) |=> alarmLow)
		else $error("reversed sensor raised no low alarm");

	// display hold entry and replacement
	a_hold_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(modeNow == HOLD_PLAIN && sQ.holdMode != HOLD_PLAIN) |=> sQ.disp == $past(sQ.pv))
		else $error("plain hold did not capture the value");
	a_max_replace: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && modeNow == HOLD_MAX && sQ.holdMode == HOLD_MAX && pvNew > sQ.disp) |=>
		sQ.disp == $past(pvNew))
		else $error("larger value not taken by max hold");
	a_min_replace: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tick && modeNow == HOLD_MIN && sQ.holdMode == HOLD_MIN && pvNew < sQ.disp) |=>
		sQ.disp == $past(pvNew))
		else $error("smaller value not taken by min hold");
	a_flash_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(modeNow == HOLD_OFF) |=> !displayFlash)
		else $error("display flashing with no hold");

	// refused setting writes leave the stored value alone
	a_range_hi_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && !isDc && regAddr == REG_RANGE_HI) |=> $stable(sQ.rangeHi))
		else $error("range high written for temperature input");
	a_dropout_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == REG_DROPOUT && $signed(regWrData) > PCT_FULL) |=>
		$stable(sQ.dropout))
		else $error("dropout above full scale accepted");
	a_range_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == REG_RANGE_LO && $signed(regWrData) < RANGE_MIN) |=>
		$stable(sQ.rangeLo))
		else $error("range low below its limit accepted");
	a_ratio_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(regWrStb && regAddr == REG_GAIN_RATIO && $signed(regWrData) < RATIO_MIN) |=>
		$stable(sQ.ratio))
		else $error("ratio below its limit accepted");
endmodule : pvic_top
`default_nettype wire

// ===== include/pvic_pkg.sv
package pvic_pkg;
	// register indices on the plain port
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_DROPOUT = 4'h1;
	localparam logic [3:0] REG_RANGE_LO = 4'h2;
	localparam logic [3:0] REG_RANGE_HI = 4'h3;
	localparam logic [3:0] REG_GAIN_RATIO = 4'h4;
	localparam logic [3:0] REG_OFFSET_BIAS = 4'h5;
	localparam logic [3:0] REG_FILTER = 4'h6;
	localparam logic [3:0] REG_DI_ASSIGN = 4'h7;
	localparam logic [3:0] REG_PROCESS_VALUE = 4'h8;
	localparam logic [3:0] REG_DISPLAY = 4'h9;
	localparam logic [3:0] REG_STATUS = 4'hA;
	// config field positions
	localparam int CFG_TYPE_LSB = 0;
	localparam int CFG_CJC_BIT = 2;
	localparam int CFG_UNDER_BIT = 3;
	localparam int CFG_DEC_LSB = 4;
	localparam int CFG_SAMP_LSB = 6;
	localparam int CFG_RANGE_LSB = 8;
	// input type codes
	localparam logic [1:0] IN_THERMO = 2'h0;
	localparam logic [1:0] IN_RTD = 2'h1;
	localparam logic [1:0] IN_DC = 2'h2;
	// digital input assignment codes
	localparam logic [1:0] DI_NONE = 2'h0;
	localparam logic [1:0] DI_HOLD = 2'h1;
	localparam logic [1:0] DI_MAX = 2'h2;
	localparam logic [1:0] DI_MIN = 2'h3;
	// reset values and setting limits (tenths of %, counts, thousandths, tenths of s)
	localparam logic [15:0] RST_RANGE_HI = 16'h03E8;
	localparam logic [15:0] RST_RATIO = 16'h03E8;
	localparam int PCT_FULL = 1000;
	localparam int RANGE_MIN = -1999;
	localparam int RANGE_MAX = 9999;
	localparam int RATIO_MIN = 1;
	localparam int RATIO_MAX = 9999;
	localparam int RATIO_ONE = 1000;
	localparam int FILTER_MAX = 1200;
	localparam int MS_PER_TENTH_S = 100;
	localparam int FS_MARGIN_DIV = 10;
	localparam int UNDER_MV_TENTHS = -50;
	localparam logic [7:0] RANGE_TYPE_A = 8'h11;
	localparam logic [7:0] RANGE_TYPE_B = 8'h17;
	// sampling periods in ms and clock period in ns
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMP_MS_0 = 50;
	localparam int SAMP_MS_1 = 100;
	localparam int SAMP_MS_2 = 300;
	localparam int SAMP_MS_3 = 500;
	localparam int SAMP_CYC_0 = SAMP_MS_0 * 1000000 / CLK_PERIOD_NS;
	localparam int SAMP_CYC_1 = SAMP_MS_1 * 1000000 / CLK_PERIOD_NS;
	localparam int SAMP_CYC_2 = SAMP_MS_2 * 1000000 / CLK_PERIOD_NS;
	localparam int SAMP_CYC_3 = SAMP_MS_3 * 1000000 / CLK_PERIOD_NS;
	// display hold modes
	typedef enum logic [1:0] {
		HOLD_OFF = 2'b00,
		HOLD_PLAIN = 2'b01,
		HOLD_MAX = 2'b10,
		HOLD_MIN = 2'b11
	} pvic_hold_type;
endpackage : pvic_pkg

// ===== testbench/pvic_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural sensor front end: digitiser values, junction and the fixed range
module pvic_sensor_model #(
	parameter logic signed [15:0] JUNCTION = 16'h000F, // junction correction offered
	parameter logic signed [15:0] FIX_LO = 16'hFFCE, // fixed range low of the table
	parameter logic signed [15:0] FIX_HI = 16'h03E8 // fixed range high of the table
) (
	input wire logic signed [15:0] pctSet,
	input wire logic signed [15:0] engSet,
	input wire logic signed [15:0] mvSet,
	input wire logic reversed,
	output logic signed [15:0] samplePct,
	output logic signed [15:0] sampleEng,
	output logic signed [15:0] junctionComp,
	output logic signed [15:0] sensorMv,
	output logic signed [15:0] fixedRangeLo,
	output logic signed [15:0] fixedRangeHi
);
	// a reversed pair of sensor leads shows up as a negated voltage
	assign sensorMv = reversed ? -mvSet : mvSet;
	assign samplePct = pctSet;
	assign sampleEng = engSet;
	assign junctionComp = JUNCTION;
	assign fixedRangeLo = FIX_LO;
	assign fixedRangeHi = FIX_HI;
endmodule : pvic_sensor_model
`default_nettype wire

// ===== testbench/pvic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_top_tb;
	import pvic_pkg::*;
	// one conditioning case: lo, hi, dropout, ratio, bias, input, pv, alarms, pv checked
	typedef struct packed {
		logic [15:0] lo, hi, drop, ratio, bias, pct, pv;
		logic aLo, aHi, chkPv;
	} pvic_row_type;
	// one display hold step: inputs, input value, expected display and flash
	typedef struct packed {
		logic [2:0] di;
		logic [15:0] pct, disp;
		logic flash;
	} pvic_hold_type_row_type;
	logic ref_clk, rst_n, regWrStb, regRdStb, reversed, displayFlash, alarmHigh, alarmLow;
	logic sampleDone;
	logic [3:0] regAddr;
	logic [15:0] regWrData, regRdData;
	logic signed [15:0] samplePct, sampleEng, junctionComp, sensorMv, fixedRangeLo, fixedRangeHi;
	logic signed [15:0] pctSet, engSet, mvSet, processValue, displayValue;
	logic [2:0] digitalIn;
	logic [1:0] decimalPos;
	int err_count = 0;
	int checks = 0;
	int n;
	pvic_row_type rows[11] = '{
		'{16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000, 16'h00FA, 16'h00FA, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0064, 16'h03E8, 16'h0000, 16'h00FA, 16'h01F4, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0064, 16'h03E8, 16'h0000, 16'h0032, 16'h0000, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0064, 16'h03E8, 16'h0000, 16'hFFE2, 16'hFFE2, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0064, 16'h03E8, 16'h0000, 16'h03E8, 16'h03E8, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0064, 16'h03E8, 16'h0000, 16'h041A, 16'h041A, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0000, 16'h07D0, 16'h0005, 16'h00FA, 16'h01F9, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0000, 16'h0001, 16'h0000, 16'h03E8, 16'h0001, 1'b0, 1'b0, 1'b1},
		'{16'h0064, 16'h012C, 16'h0000, 16'h03E8, 16'h0000, 16'h01F4, 16'h00C8, 1'b0, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000, 16'hFF6A, 16'hFF9C, 1'b1, 1'b0, 1'b1},
		'{16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 16'hFE0C, 16'h04B0, 16'h02BC, 1'b0, 1'b1, 1'b1}
	};
	// hold, back to follow, max, max, min, min, hold over max, release
	pvic_hold_type_row_type holds[8] = '{
		'{3'h1, 16'h01F4, 16'h012C, 1'b1}, '{3'h0, 16'h01F4, 16'h01F4, 1'b0},
		'{3'h2, 16'h0190, 16'h01F4, 1'b1}, '{3'h2, 16'h02BC, 16'h02BC, 1'b1},
		'{3'h4, 16'h0320, 16'h02BC, 1'b1}, '{3'h4, 16'h00C8, 16'h00C8, 1'b1},
		'{3'h3, 16'h0384, 16'h00C8, 1'b1}, '{3'h0, 16'h0384, 16'h0384, 1'b0}
	};
	int per[4] = '{20, 40, 60, 100};
	// short sample periods keep the run brief
	pvic_top #(.SAMP_CYC_50(20), .SAMP_CYC_100(40), .SAMP_CYC_300(60), .SAMP_CYC_500(100))
	pvic_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .samplePct(samplePct),
		.sampleEng(sampleEng), .junctionComp(junctionComp), .sensorMv(sensorMv),
		.fixedRangeLo(fixedRangeLo), .fixedRangeHi(fixedRangeHi), .digitalIn(digitalIn),
		.processValue(processValue), .displayValue(displayValue), .displayFlash(displayFlash),
		.alarmHigh(alarmHigh), .alarmLow(alarmLow), .sampleDone(sampleDone),
		.decimalPos(decimalPos));
	pvic_sensor_model pvic_sensor_model_i (.pctSet(pctSet), .engSet(engSet), .mvSet(mvSet),
		.reversed(reversed), .samplePct(samplePct), .sampleEng(sampleEng),
		.junctionComp(junctionComp), .sensorMv(sensorMv), .fixedRangeLo(fixedRangeLo),
		.fixedRangeHi(fixedRangeHi));
	// verdict and end of run, shared with the watchdog
	task automatic print_verdict();
		if (err_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk
	// one-cycle write strobe beside address and data
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe, so look mid-cycle there
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		@(negedge ref_clk);
		chk(name, exp, regRdData);
	endtask : rd
	// waits for sample pulses with a bound, so a dead tick shows as a mismatch
	task automatic waitSample(input int cnt);
		int k;
		repeat (cnt) begin
			k = 0;
			@(negedge ref_clk);
			while (sampleDone !== 1'b1 && k < 300) begin
				@(negedge ref_clk);
				k++;
			end
			if (k >= 300) chk("sampleDone", 16'h0001, 16'h0000);
		end
	endtask : waitSample
	task automatic setPct(input logic [15:0] v);
		@(posedge ref_clk);
		pctSet <= v;
	endtask : setPct
	// clock source
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// watchdog, far beyond the few thousand cycles the tests need
	initial begin
		#1000000;
		err_count++;
		print_verdict();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		{regWrStb, regRdStb, reversed, digitalIn, regAddr} = '0;
		{regWrData, pctSet, mvSet} = '0;
		engSet = 16'h00C8;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk("decimalPos", 16'h0000, {14'h0, decimalPos});
		// stored range defaults only show once the input is DC
		wr(REG_CONFIG, 16'h0002);
		rd(REG_RANGE_LO, 16'h0000, "range lo");
		rd(REG_RANGE_HI, RST_RANGE_HI, "range hi");
		rd(REG_GAIN_RATIO, RST_RATIO, "ratio");
		rd(REG_DROPOUT, 16'h0000, "dropout");
		rd(REG_FILTER, 16'h0000, "filter");
		rd(4'hF, 16'h0000, "unmapped");
		foreach (rows[i]) begin
			wr(REG_RANGE_LO, rows[i].lo);
			wr(REG_RANGE_HI, rows[i].hi);
			wr(REG_DROPOUT, rows[i].drop);
			wr(REG_GAIN_RATIO, rows[i].ratio);
			wr(REG_OFFSET_BIAS, rows[i].bias);
			setPct(rows[i].pct);
			waitSample(2);
			if (rows[i].chkPv) chk("processValue", rows[i].pv, processValue);
			chk("alarmLow", {15'h0, rows[i].aLo}, {15'h0, alarmLow});
			chk("alarmHigh", {15'h0, rows[i].aHi}, {15'h0, alarmHigh});
		end
		wr(REG_OFFSET_BIAS, 16'h0000);
		// setting limits: boundary accepted, one past refused; the filter is checked on the refusal only
		wr(REG_DROPOUT, 16'h03E8);
		wr(REG_DROPOUT, 16'h03E9);
		rd(REG_DROPOUT, 16'h03E8, "dropout");
		wr(REG_GAIN_RATIO, 16'h0001);
		wr(REG_GAIN_RATIO, 16'h0000);
		rd(REG_GAIN_RATIO, 16'h0001, "ratio");
		wr(REG_RANGE_LO, 16'hF831);
		wr(REG_RANGE_LO, 16'hF830);
		rd(REG_RANGE_LO, 16'hF831, "range lo");
		wr(REG_RANGE_HI, 16'h270F);
		wr(REG_RANGE_HI, 16'h2710);
		rd(REG_RANGE_HI, 16'h270F, "range hi");
		wr(REG_FILTER, 16'h04B1);
		rd(REG_FILTER, 16'h0000, "filter");
		for (int d = 0; d < 4; d++) begin
			wr(REG_CONFIG, {10'h0, d[1:0], 4'h2});
			@(negedge ref_clk);
			@(negedge ref_clk);
			chk("decimalPos", d[15:0], {14'h0, decimalPos});
		end
		// sampling period for each selection, measured between two pulses
		for (int s = 0; s < 4; s++) begin
			wr(REG_CONFIG, {8'h0, s[1:0], 6'h2});
			waitSample(2);
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (sampleDone !== 1'b1 && n < 300);
			chk("period", per[s][15:0], n[15:0]);
		end
		// filter: 1.0 s at 50 ms gives a divisor of 21
		wr(REG_CONFIG, 16'h0002);
		wr(REG_RANGE_LO, 16'h0000);
		wr(REG_RANGE_HI, 16'h03E8);
		wr(REG_GAIN_RATIO, 16'h03E8);
		wr(REG_DROPOUT, 16'h0000);
		// settle at zero unfiltered, arm the filter, then step just after a pulse
		setPct(16'h0000);
		waitSample(2);
		wr(REG_FILTER, 16'h000A);
		waitSample(1);
		setPct(16'h01A4);
		waitSample(1);
		chk("filter step 1", 16'h0014, processValue);
		waitSample(1);
		chk("filter step 2", 16'h0027, processValue);
		wr(REG_FILTER, 16'h0000);
		waitSample(2);
		chk("bypass", 16'h01A4, processValue);
		// display hold sequence, plain then max then min then plain over max
		wr(REG_DI_ASSIGN, 16'h0039);
		setPct(16'h012C);
		waitSample(2);
		foreach (holds[i]) begin
			@(posedge ref_clk);
			digitalIn <= holds[i].di;
			pctSet <= holds[i].pct;
			waitSample(2);
			chk("displayValue", holds[i].disp, displayValue);
			chk("displayFlash", {15'h0, holds[i].flash}, {15'h0, displayFlash});
		end
		// unassigned inputs change nothing on the display
		wr(REG_DI_ASSIGN, 16'h0000);
		@(posedge ref_clk);
		digitalIn <= 3'h7;
		waitSample(2);
		chk("displayFlash", 16'h0000, {15'h0, displayFlash});
		chk("displayValue", 16'h0384, displayValue);
		@(posedge ref_clk);
		digitalIn <= 3'h0;
		// thermocouple: internal correction adds the junction term, external skips it
		wr(REG_CONFIG, 16'h0000);
		waitSample(2);
		chk("processValue", 16'h00D7, processValue);
		rd(REG_RANGE_LO, 16'hFFCE, "fixed lo");
		wr(REG_RANGE_LO, 16'h0005);
		rd(REG_RANGE_LO, 16'hFFCE, "fixed lo");
		wr(REG_CONFIG, 16'h0004);
		waitSample(2);
		chk("processValue", 16'h00C8, processValue);
		// under-range: -5 mV type on both ranges, normal and reversed leads
		@(posedge ref_clk);
		mvSet <= 16'h003C;
		for (int u = 0; u < 5; u++) begin
			wr(REG_CONFIG, u == 4 ? 16'h1100 : (u > 1 ? 16'h1708 : 16'h1108));
			@(posedge ref_clk);
			reversed <= (u != 0 && u != 2);
			waitSample(2);
			chk("alarmLow", {15'h0, u == 1 || u == 3}, {15'h0, alarmLow});
		end
		// the refused temperature-mode write must not have reached the stored limit
		wr(REG_CONFIG, 16'h0002);
		rd(REG_RANGE_LO, 16'h0000, "range lo");
		print_verdict();
	end
endmodule : pvic_top_tb
`default_nettype wire
